//--- verilog/upcr_pkg.sv
package upcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses: read at any of the three, write, set, clear
    localparam int unsigned UPCR_ADDR_W         = 6;
    localparam logic [5:0]  UPCR_FUNC_WRITE     = 6'h04;
    localparam logic [5:0]  UPCR_FUNC_SET       = 6'h05;
    localparam logic [5:0]  UPCR_FUNC_CLEAR     = 6'h06;
    localparam logic [5:0]  UPCR_INTF_WRITE     = 6'h07;
    localparam logic [5:0]  UPCR_INTF_SET       = 6'h08;
    localparam logic [5:0]  UPCR_INTF_CLEAR     = 6'h09;
    localparam logic [5:0]  UPCR_OTG_WRITE      = 6'h0A;
    localparam logic [5:0]  UPCR_OTG_SET        = 6'h0B;
    localparam logic [5:0]  UPCR_OTG_CLEAR      = 6'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and storable-bit masks
    localparam logic [7:0]  UPCR_FUNC_RESET     = 8'h41;
    localparam logic [7:0]  UPCR_FUNC_MASK      = 8'h5F;
    localparam logic [7:0]  UPCR_INTF_RESET     = 8'h00;
    localparam logic [7:0]  UPCR_INTF_MASK      = 8'hEB;
    localparam logic [7:0]  UPCR_OTG_RESET      = 8'h06;
    localparam logic [7:0]  UPCR_OTG_MASK       = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned UPCR_SUSPEND_BIT    = 6;
    localparam int unsigned UPCR_TX_ENCODING_MODE_LSB     = 3;
    localparam int unsigned UPCR_TERMSEL_BIT    = 2;
    localparam int unsigned UPCR_SPEED_LSB      = 0;
    localparam int unsigned UPCR_PROT_DIS_BIT   = 7;
    localparam int unsigned UPCR_BYPASS_BIT     = 6;
    localparam int unsigned UPCR_INVERT_BIT     = 5;
    localparam int unsigned UPCR_CLK_KEEP_BIT   = 3;
    localparam int unsigned UPCR_THREE_WIRE_BIT = 1;
    localparam int unsigned UPCR_SIX_WIRE_BIT   = 0;

    ////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [1:0] {
        UPCR_TX_NORMAL    = 2'b00,
        UPCR_TX_NODRIVE   = 2'b01,
        UPCR_TX_RAW       = 2'b10,
        UPCR_TX_NO_SYNC   = 2'b11
    } upcr_tx_mode_e;

    typedef enum logic [1:0] {
        UPCR_SPD_HIGH     = 2'b00,
        UPCR_SPD_FULL     = 2'b01,
        UPCR_SPD_LOW      = 2'b10,
        UPCR_SPD_PREAMBLE = 2'b11
    } upcr_speed_e;

endpackage : upcr_pkg

//--- verilog/upcr_reg_slice.sv
module upcr_reg_slice
    import upcr_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] BIT_MASK  = 8'hFF
)(
    // Clock and control
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    // Software access
    input  wire logic       wr_in,
    input  wire logic       set_in,
    input  wire logic       clr_in,
    input  wire logic [7:0] wdata_in,
    // Hardware updates
    input  wire logic [7:0] hw_set_in,
    input  wire logic [7:0] hw_clr_in,
    // Stored value
    output logic      [7:0] value_out
);

    logic [7:0] value_q;
    logic [7:0] value_d;
    logic [7:0] hw_base;

    // Hardware updates first, software access on top of them
    assign hw_base = (value_q & ~hw_clr_in) | hw_set_in;

    // RL20 write set clear
    always_comb
    begin
        if (wr_in)
            value_d = wdata_in;
        else if (set_in)
            value_d = hw_base | wdata_in;
        else if (clr_in)
            value_d = hw_base & ~wdata_in;
        else
            value_d = hw_base;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            value_q <= RESET_VAL;
        else if (ce_in)
            value_q <= value_d & BIT_MASK;
    end

    assign value_out = value_q;

endmodule : upcr_reg_slice

//--- verilog/upcr_regs.sv
// Functional notes
// RL1 - Encoding mode 00 transmits normally with stuffing, NRZI, SYNC and EOP; reset value.
// RL2 - Mode 01 stops driving; 10 drops stuffing and NRZI; 11 drops SYNC and EOP.
// RL3 - Link uses mode 11 only for high-speed packets.
// RL4 - Termination bit steers pull-up and HS terminations with speed, mode and pull-downs.
// RL5 - Speed field picks HS, FS (reset), LS, or FS with automatic preamble.
// RL6 - Interface register read 07h-09h, write 07h, set 08h, clear 09h; bits 4,2 reserved.
// RL7 - Link enables at most one alternative interface mode at a time.
// RL8 - Protection on: weak pull-up on stop; stop unexpectedly high pulls data lines down.
// RL9 - Protection disable removes stop pull-up and data pull-downs.
// RL10 - Bypass bit uses inverted indicator directly or qualified by A-device comparator.
// RL11 - Invert bit complements the external overcurrent indicator input.
// RL12 - Clock keep bit matters only in serial modes; zero leaves the clock unpowered.
// RL13 - Active-low suspend zero enters low power; one, the reset value, stays powered.
// RL14 - Clock keep bit ignored unless active-low suspend is one.
// RL15 - Three-wire serial bit selects 3-bit serial FS/LS; hardware clears it on exit.
// RL16 - Six-wire serial bit selects 6-bit serial FS/LS; hardware clears it on exit.
// RL17 - Both serial bits clear means FS/LS packets use the parallel interface.
// RL18 - OTG register read 0Ah-0Ch, write 0Ah, set 0Bh, clear 0Ch; bit layout fixed.
// RL19 - OTG register resets with only both data-line pull-downs set.
// RL20 - Set address sets ones, clear address clears ones, write address replaces.
module upcr_regs
    import upcr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   ce_in,
    // Register access from the link
    input  wire logic [UPCR_ADDR_W-1:0] reg_addr_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [7:0]             reg_wdata_in,
    output logic      [7:0]             reg_rdata_out,
    // Pins and comparators from outside the clock domain
    input  wire logic                   stop_line_in,
    input  wire logic                   fault_line_in,
    input  wire logic                   a_vbus_valid_in,
    // Same-domain state events
    input  wire logic                   stop_expected_in,
    input  wire logic                   serial_exit_in,
    input  wire logic                   low_power_exit_in,
    // Transmit control
    output logic                        tx_drive_enable_out,
    output logic                        tx_stuff_nrzi_enable_out,
    output logic                        tx_auto_sync_eop_out,
    // Transceiver select
    output logic                        hs_xcvr_enable_out,
    output logic                        fs_xcvr_enable_out,
    output logic                        ls_xcvr_enable_out,
    output logic                        fs_preamble_enable_out,
    // Bus resistors
    output logic                        plus_pullup_enable_out,
    output logic                        minus_pullup_enable_out,
    output logic                        hs_termination_enable_out,
    output logic                        plus_line_pulldown_enable_out,
    output logic                        minus_line_pulldown_enable_out,
    // Interface protection
    output logic                        stop_pullup_enable_out,
    output logic                        data_pulldown_enable_out,
    // Power and interface mode
    output logic                        low_power_out,
    output logic                        clock_powered_out,
    output logic                        three_wire_active_out,
    output logic                        six_wire_active_out,
    output logic                        parallel_active_out,
    // Indicator and OTG controls
    output logic                        vbus_state_valid_out,
    output logic                        external_indicator_select_out,
    output logic                        external_supply_select_out,
    output logic                        vbus_drive_enable_out,
    output logic                        vbus_charge_enable_out,
    output logic                        vbus_discharge_enable_out,
    output logic                        id_line_sampler_enable_out
);

    function automatic logic upcr_hit(input logic [5:0] addr, input logic [5:0] base);
        upcr_hit = (addr == base);
    endfunction : upcr_hit

    function automatic logic upcr_in_range(input logic [5:0] addr, input logic [5:0] base);
        upcr_in_range = (addr >= base) && (addr <= base + 6'h02);
    endfunction : upcr_in_range

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [7:0] func_q;
    logic [7:0] intf_q;
    logic [7:0] otg_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       wr_ok;
    logic       func_wr;
    logic       func_set;
    logic       func_clr;
    logic       intf_wr;
    logic       intf_set;
    logic       intf_clr;
    logic       otg_wr;
    logic       otg_set;
    logic       otg_clr;

    assign wr_ok    = reg_wr_in && ce_in;
    assign func_wr  = wr_ok && upcr_hit(reg_addr_in, UPCR_FUNC_WRITE);
    assign func_set = wr_ok && upcr_hit(reg_addr_in, UPCR_FUNC_SET);
    assign func_clr = wr_ok && upcr_hit(reg_addr_in, UPCR_FUNC_CLEAR);
    // RL6 interface register decode
    assign intf_wr  = wr_ok && upcr_hit(reg_addr_in, UPCR_INTF_WRITE);
    assign intf_set = wr_ok && upcr_hit(reg_addr_in, UPCR_INTF_SET);
    assign intf_clr = wr_ok && upcr_hit(reg_addr_in, UPCR_INTF_CLEAR);
    // RL18 OTG register decode
    assign otg_wr   = wr_ok && upcr_hit(reg_addr_in, UPCR_OTG_WRITE);
    assign otg_set  = wr_ok && upcr_hit(reg_addr_in, UPCR_OTG_SET);
    assign otg_clr  = wr_ok && upcr_hit(reg_addr_in, UPCR_OTG_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] func_hw_set;
    logic [7:0] intf_hw_clr;

    // RL13 wake-up restores powered state
    assign func_hw_set = {1'b0, low_power_exit_in, 6'h00};
    // RL15 RL16 serial exit self-clear
    assign intf_hw_clr = {6'h00, serial_exit_in, serial_exit_in};

    upcr_reg_slice #(.RESET_VAL(UPCR_FUNC_RESET), .BIT_MASK(UPCR_FUNC_MASK)) u_func (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .wr_in      (func_wr),
        .set_in     (func_set),
        .clr_in     (func_clr),
        .wdata_in   (reg_wdata_in),
        .hw_set_in  (func_hw_set),
        .hw_clr_in  (8'h00),
        .value_out  (func_q)
    );

    upcr_reg_slice #(.RESET_VAL(UPCR_INTF_RESET), .BIT_MASK(UPCR_INTF_MASK)) u_intf (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .wr_in      (intf_wr),
        .set_in     (intf_set),
        .clr_in     (intf_clr),
        .wdata_in   (reg_wdata_in),
        .hw_set_in  (8'h00),
        .hw_clr_in  (intf_hw_clr),
        .value_out  (intf_q)
    );

    // RL19 OTG reset value
    upcr_reg_slice #(.RESET_VAL(UPCR_OTG_RESET), .BIT_MASK(UPCR_OTG_MASK)) u_otg (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .wr_in      (otg_wr),
        .set_in     (otg_set),
        .clr_in     (otg_clr),
        .wdata_in   (reg_wdata_in),
        .hw_set_in  (8'h00),
        .hw_clr_in  (8'h00),
        .value_out  (otg_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path: any of the three addresses returns the register
    logic rd_func;
    logic rd_intf;
    logic rd_otg;

    assign rd_func = upcr_in_range(reg_addr_in, UPCR_FUNC_WRITE);
    assign rd_intf = upcr_in_range(reg_addr_in, UPCR_INTF_WRITE);
    assign rd_otg  = upcr_in_range(reg_addr_in, UPCR_OTG_WRITE);
    assign rdata_d = rd_func ? func_q : rd_intf ? intf_q : rd_otg ? otg_q : 8'h00;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            rdata_q <= 8'h00;
        else if (ce_in && reg_rd_in)
            rdata_q <= rdata_d;
    end

    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage feeds only the second
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end
        else if (ce_in)
        begin
            pin_meta_q <= {a_vbus_valid_in, fault_line_in, stop_line_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Function control decode
    upcr_tx_mode_e tx_mode;
    upcr_speed_e   speed_sel;
    logic          term_sel;

    assign tx_mode   = upcr_tx_mode_e'(func_q[UPCR_TX_ENCODING_MODE_LSB +: 2]);
    assign speed_sel = upcr_speed_e'(func_q[UPCR_SPEED_LSB +: 2]);
    assign term_sel  = func_q[UPCR_TERMSEL_BIT];

    // RL1 RL2 transmit encoding
    assign tx_drive_enable_out      = (tx_mode != UPCR_TX_NODRIVE);
    assign tx_stuff_nrzi_enable_out = (tx_mode == UPCR_TX_NORMAL) || (tx_mode == UPCR_TX_NO_SYNC);
    assign tx_auto_sync_eop_out     = (tx_mode == UPCR_TX_NORMAL) || (tx_mode == UPCR_TX_RAW);

    // RL5 transceiver select
    assign hs_xcvr_enable_out     = (speed_sel == UPCR_SPD_HIGH);
    assign fs_xcvr_enable_out     = (speed_sel == UPCR_SPD_FULL) || (speed_sel == UPCR_SPD_PREAMBLE);
    assign ls_xcvr_enable_out     = (speed_sel == UPCR_SPD_LOW);
    assign fs_preamble_enable_out = (speed_sel == UPCR_SPD_PREAMBLE);

    // RL4 resistor selection; a pulled-down line never also gets the pull-up
    assign plus_pullup_enable_out    = term_sel && !otg_q[1] && (tx_mode != UPCR_TX_RAW || !hs_xcvr_enable_out)
                                       && (speed_sel != UPCR_SPD_LOW);
    assign minus_pullup_enable_out   = term_sel && !otg_q[2] && (speed_sel == UPCR_SPD_LOW);
    assign hs_termination_enable_out = !term_sel && hs_xcvr_enable_out && (tx_mode != UPCR_TX_NODRIVE);
    assign plus_line_pulldown_enable_out  = otg_q[1];
    assign minus_line_pulldown_enable_out = otg_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Interface control behaviour
    logic protect_on;
    logic indicator;
    logic suspend_high;
    logic serial_mode;

    // RL8 RL9 interface protection
    assign protect_on               = !intf_q[UPCR_PROT_DIS_BIT];
    assign stop_pullup_enable_out   = protect_on;
    assign data_pulldown_enable_out = protect_on && pin_sync_q[0] && !stop_expected_in;

    // RL11 indicator inversion
    assign indicator = pin_sync_q[1] ^ intf_q[UPCR_INVERT_BIT];
    // RL10 comparator qualification
    assign vbus_state_valid_out = intf_q[UPCR_BYPASS_BIT] ? indicator : (indicator && pin_sync_q[2]);

    // RL13 suspend control
    assign suspend_high  = func_q[UPCR_SUSPEND_BIT];
    assign low_power_out = !suspend_high;

    // RL17 parallel unless a serial mode is set; several set at once is undefined
    assign three_wire_active_out = intf_q[UPCR_THREE_WIRE_BIT];
    assign six_wire_active_out   = intf_q[UPCR_SIX_WIRE_BIT];
    assign serial_mode           = three_wire_active_out || six_wire_active_out;
    assign parallel_active_out   = !serial_mode;

    // RL12 RL14 clock power in serial modes
    assign clock_powered_out = suspend_high && (!serial_mode || intf_q[UPCR_CLK_KEEP_BIT]);

    // RL18 OTG bit layout
    assign external_indicator_select_out = otg_q[7];
    assign external_supply_select_out    = otg_q[6];
    assign vbus_drive_enable_out         = otg_q[5];
    assign vbus_charge_enable_out        = otg_q[4];
    assign vbus_discharge_enable_out     = otg_q[3];
    assign id_line_sampler_enable_out    = otg_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_normal_mode;
        func_wr && reg_wdata_in[4:3] == 2'b00
            |=> tx_drive_enable_out && tx_stuff_nrzi_enable_out && tx_auto_sync_eop_out;
    endproperty
    a_normal_mode: assert property (p_normal_mode) else $error("normal mode not applied"); // RL1

    property p_nodrive_mode;
        func_wr && reg_wdata_in[4:3] == 2'b01 |=> !tx_drive_enable_out && !hs_termination_enable_out;
    endproperty
    a_nodrive_mode: assert property (p_nodrive_mode) else $error("non-driving mode still drives"); // RL2

    property p_speed_high;
        func_wr && reg_wdata_in[1:0] == 2'b00 |=> hs_xcvr_enable_out && !fs_xcvr_enable_out;
    endproperty
    a_speed_high: assert property (p_speed_high) else $error("high-speed select wrong"); // RL5

    property p_reserved_zero;
        ce_in && reg_rd_in && upcr_in_range(reg_addr_in, UPCR_INTF_WRITE)
            |=> reg_rdata_out[4] == 1'b0 && reg_rdata_out[2] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one"); // RL6

    property p_protect_pulldown;
        (ce_in && stop_line_in && protect_on && !stop_expected_in)[*3] |-> data_pulldown_enable_out;
    endproperty
    a_protect_pulldown: assert property (p_protect_pulldown) else $error("data pull-downs missing"); // RL8

    property p_protect_off;
        intf_wr && reg_wdata_in[7] |=> !stop_pullup_enable_out && !data_pulldown_enable_out;
    endproperty
    a_protect_off: assert property (p_protect_off) else $error("protection still attached"); // RL9

    property p_clock_ignored;
        func_clr && reg_wdata_in[6] && !low_power_exit_in |=> !clock_powered_out;
    endproperty
    a_clock_ignored: assert property (p_clock_ignored) else $error("clock powered in suspend"); // RL14

    property p_serial_exit;
        ce_in && serial_exit_in && !intf_wr && !intf_set |=> !three_wire_active_out && !six_wire_active_out;
    endproperty
    a_serial_exit: assert property (p_serial_exit) else $error("serial bit not cleared"); // RL15

    property p_otg_reset;
        $rose(rst_n_in) |-> otg_q == UPCR_OTG_RESET && intf_q == UPCR_INTF_RESET;
    endproperty
    a_otg_reset: assert property (p_otg_reset) else $error("reset value wrong"); // RL19

    property p_otg_set;
        otg_set |=> otg_q == ($past(otg_q) | $past(reg_wdata_in));
    endproperty
    a_otg_set: assert property (p_otg_set) else $error("set address misbehaves"); // RL20

    c_three_wire: cover property (intf_set && reg_wdata_in[1] ##1 three_wire_active_out);
    c_low_power:  cover property (func_clr && reg_wdata_in[6] ##1 low_power_out);
    c_otg_read:   cover property (ce_in && reg_rd_in && reg_addr_in == UPCR_OTG_CLEAR);

endmodule : upcr_regs

//--- test/upcr_link_model.sv
module upcr_link_model
    import upcr_pkg::*;
(
    // Clock
    input  wire logic                   ref_clk_in,
    // Register access
    output logic      [UPCR_ADDR_W-1:0] reg_addr_out,
    output logic                        reg_wr_out,
    output logic                        reg_rd_out,
    output logic      [7:0]             reg_wdata_out,
    input  wire logic [7:0]             reg_rdata_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_addr_out  = '0;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_wdata_out = 8'h00;
    end

    task automatic access(input logic [5:0] addr, input logic wr, input logic [7:0] wdata);
        @(posedge ref_clk_in);
        #1;
        reg_addr_out  = addr;
        reg_wdata_out = wdata;
        reg_wr_out    = wr;
        reg_rd_out    = !wr;
        @(posedge ref_clk_in);
        #1;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        // Released lines toggle so stale values cannot pass for answers
        reg_addr_out  = ~addr;
        reg_wdata_out = ~wdata;
    endtask : access

endmodule : upcr_link_model

//--- test/tb_upcr_regs.sv
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin failures++; \
    $display("ERROR %0t: got %h expected %h", $time, act, exp); end end

module tb_upcr_regs
    import upcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk_in, rst_n_in, ce_in, reg_wr_in, reg_rd_in;
    logic [5:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic stop_line_in, fault_line_in, a_vbus_valid_in, stop_expected_in, serial_exit_in, low_power_exit_in;
    logic tx_drive_enable_out, tx_stuff_nrzi_enable_out, tx_auto_sync_eop_out;
    logic hs_xcvr_enable_out, fs_xcvr_enable_out, ls_xcvr_enable_out, fs_preamble_enable_out;
    logic plus_pullup_enable_out, minus_pullup_enable_out, hs_termination_enable_out;
    logic plus_line_pulldown_enable_out, minus_line_pulldown_enable_out;
    logic stop_pullup_enable_out, data_pulldown_enable_out, low_power_out, clock_powered_out;
    logic three_wire_active_out, six_wire_active_out, parallel_active_out, vbus_state_valid_out;
    logic external_indicator_select_out, external_supply_select_out, vbus_drive_enable_out;
    logic vbus_charge_enable_out, vbus_discharge_enable_out, id_line_sampler_enable_out;
    int   failures = 0;
    int   checks = 0;
    int   cycles = 0;

    upcr_regs i_dut (.ref_clk_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
        .reg_rdata_out, .stop_line_in, .fault_line_in, .a_vbus_valid_in, .stop_expected_in, .serial_exit_in,
        .low_power_exit_in, .tx_drive_enable_out, .tx_stuff_nrzi_enable_out, .tx_auto_sync_eop_out,
        .hs_xcvr_enable_out, .fs_xcvr_enable_out, .ls_xcvr_enable_out, .fs_preamble_enable_out,
        .plus_pullup_enable_out, .minus_pullup_enable_out, .hs_termination_enable_out,
        .plus_line_pulldown_enable_out, .minus_line_pulldown_enable_out, .stop_pullup_enable_out,
        .data_pulldown_enable_out, .low_power_out, .clock_powered_out, .three_wire_active_out,
        .six_wire_active_out, .parallel_active_out, .vbus_state_valid_out, .external_indicator_select_out,
        .external_supply_select_out, .vbus_drive_enable_out, .vbus_charge_enable_out,
        .vbus_discharge_enable_out, .id_line_sampler_enable_out);

    upcr_link_model i_link (.ref_clk_in(ref_clk_in), .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
        .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));

    always #5 ref_clk_in = ~ref_clk_in;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            end_sim();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : cyc

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_link.access(a, 1'b1, d);
    endtask : wr

    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        i_link.access(a, 1'b0, 8'h00);
        `CHK(reg_rdata_out, exp)
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk_in = 1'b0;
        rst_n_in = 1'b0;
        ce_in = 1'b1;
        {stop_line_in, fault_line_in, a_vbus_valid_in} = 3'b000;
        {stop_expected_in, serial_exit_in, low_power_exit_in} = 3'b000;
        cyc(16);
        rst_n_in = 1'b1;
        rdc(UPCR_FUNC_CLEAR, 8'h41);
        rdc(UPCR_INTF_SET, 8'h00);
        rdc(UPCR_OTG_CLEAR, 8'h06);
        `CHK({tx_drive_enable_out, tx_stuff_nrzi_enable_out, tx_auto_sync_eop_out}, 3'b111)
        `CHK({parallel_active_out, low_power_out, stop_pullup_enable_out}, 3'b101)
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 4; s++)
            begin
                // no-SYNC mode only at high speed
                if (m == 3 && s != 0)
                    continue;
                wr(UPCR_FUNC_WRITE, 8'h40 | 8'(m << 3) | 8'(s));
                `CHK(tx_drive_enable_out, m != 1)
                if (m != 1)
                    `CHK({tx_stuff_nrzi_enable_out, tx_auto_sync_eop_out}, {m != 2, m != 3})
                `CHK({hs_xcvr_enable_out, ls_xcvr_enable_out, fs_preamble_enable_out}, {s == 0, s == 2, s == 3})
                `CHK(fs_xcvr_enable_out, s == 1 || s == 3)
                `CHK({hs_termination_enable_out, plus_pullup_enable_out}, {s == 0 && m != 1, 1'b0})
            end
        wr(UPCR_OTG_WRITE, 8'hA5);
        `CHK({external_indicator_select_out, external_supply_select_out, vbus_drive_enable_out,
              vbus_charge_enable_out, vbus_discharge_enable_out, minus_line_pulldown_enable_out,
              plus_line_pulldown_enable_out, id_line_sampler_enable_out}, 8'hA5)
        wr(UPCR_OTG_CLEAR, 8'h21);
        rdc(UPCR_OTG_SET, 8'h84);
        wr(UPCR_OTG_SET, 8'h02);
        rdc(UPCR_OTG_WRITE, 8'h86);
        wr(UPCR_OTG_CLEAR, 8'h02);
        wr(UPCR_FUNC_WRITE, 8'h46);
        `CHK({minus_pullup_enable_out, plus_pullup_enable_out}, 2'b00)
        wr(UPCR_OTG_CLEAR, 8'h04);
        `CHK({minus_pullup_enable_out, minus_line_pulldown_enable_out}, 2'b10)
        wr(UPCR_OTG_SET, 8'h04);
        wr(UPCR_FUNC_WRITE, 8'h45);
        `CHK({plus_pullup_enable_out, hs_termination_enable_out}, 2'b10)
        ce_in = 1'b0;
        wr(UPCR_OTG_WRITE, 8'h00);
        ce_in = 1'b1;
        rdc(UPCR_OTG_CLEAR, 8'h84);
        rdc(6'h20, 8'h00);
        wr(UPCR_INTF_SET, 8'h02);
        `CHK({three_wire_active_out, parallel_active_out}, 2'b10)
        wr(UPCR_INTF_SET, 8'h08);
        rdc(UPCR_INTF_CLEAR, 8'h0A);
        `CHK(clock_powered_out, 1'b1)
        wr(UPCR_INTF_CLEAR, 8'h02);
        rdc(UPCR_INTF_SET, 8'h08);
        `CHK(parallel_active_out, 1'b1)
        // only one serial mode at a time
        wr(UPCR_INTF_WRITE, 8'hFD);
        rdc(UPCR_INTF_WRITE, 8'hE9);
        `CHK({six_wire_active_out, stop_pullup_enable_out}, 2'b10)
        wr(UPCR_INTF_CLEAR, 8'h08);
        `CHK(clock_powered_out, 1'b0)
        serial_exit_in = 1'b1;
        cyc(1);
        serial_exit_in = 1'b0;
        `CHK({six_wire_active_out, parallel_active_out}, 2'b01)
        wr(UPCR_INTF_WRITE, 8'h09);
        wr(UPCR_FUNC_CLEAR, 8'h40);
        `CHK({low_power_out, clock_powered_out}, 2'b10)
        low_power_exit_in = 1'b1;
        cyc(1);
        low_power_exit_in = 1'b0;
        `CHK({low_power_out, clock_powered_out}, 2'b01)
        wr(UPCR_INTF_WRITE, 8'h00);
        stop_line_in = 1'b1;
        cyc(3);
        `CHK({stop_pullup_enable_out, data_pulldown_enable_out}, 2'b11)
        stop_expected_in = 1'b1;
        cyc(1);
        `CHK(data_pulldown_enable_out, 1'b0)
        stop_expected_in = 1'b0;
        wr(UPCR_INTF_SET, 8'h80);
        `CHK({stop_pullup_enable_out, data_pulldown_enable_out}, 2'b00)
        a_vbus_valid_in = 1'b1;
        wr(UPCR_INTF_WRITE, 8'h20);
        cyc(3);
        `CHK(vbus_state_valid_out, 1'b1)
        wr(UPCR_INTF_WRITE, 8'h00);
        `CHK(vbus_state_valid_out, 1'b0)
        {a_vbus_valid_in, fault_line_in} = 2'b01;
        cyc(3);
        `CHK(vbus_state_valid_out, 1'b0)
        wr(UPCR_INTF_WRITE, 8'h40);
        `CHK(vbus_state_valid_out, 1'b1)
        end_sim();
    end

endmodule : tb_upcr_regs
